// ==== hdl/rtadr_top.sv ====
// terminal address selection, latch, parity check and shared discrete output
// assumes axi4-lite on i_core_clk; strap pins and latch input are asynchronous
//
// How it works
// RL1: source bit clear selects address and parity from the strap pins.
// RL2: source bit set selects address and parity from host data bits 5..0.
// RL3: non-broadcast response allowed only when six address bits hold odd ones.
// RL4: latch input low makes the pin address transparent.
// RL5: rising latch input captures the pin address and parity.
// RL6: host latches via enhanced bit, latch-on-write bit, then register 5 write.
// RL7: host places address and parity in low six bits of register 5.
// RL8: source bit clear ignores register 5 data and latches the pins instead.
// RL9: register 7 bit 0 picks in-progress indicator or reset pulse.
// RL10: controller, terminal, selective monitor: indicator low while a message runs.
// RL11: word monitor: indicator low for the whole online time.
// RL12: terminal with pulse selected: output low two clocks after reset command.
// RL13: controller or monitor with pulse selected: output stays high.
// RL14: transmitter inhibit high shuts both transmitters down.
// RL15: master clear is an active-low reset.
// RL16: terminal clock may be 20, 16, 12 or 10 MHz.
// RL17: registers are 16 bits in low half of 32-bit slots, 00h to FCh.
// RL18: latched address holds until the next latch event.
module rtadr_top #(
  parameter int TERM_CLK_MHZ = 20
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic [4:0]  i_terminal_address_pins,
  input  wire logic        i_terminal_address_parity_pin,
  input  wire logic        i_address_latch_control,
  input  wire logic        i_transmitter_inhibit,
  input  wire logic        i_msg_busy,
  input  wire logic        i_reset_cmd,
  input  wire logic        i_nonbcast_cmd,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [5:0]       o_terminal_address,
  output logic             o_address_ok,
  output logic             o_respond,
  output logic             o_tx_enable_a,
  output logic             o_tx_enable_b,
  output logic             o_discrete_n
);

  // [RL16] only the four supported terminal clock rates are served
  if (TERM_CLK_MHZ != 20 && TERM_CLK_MHZ != 16 && TERM_CLK_MHZ != 12 &&
      TERM_CLK_MHZ != 10) begin : g_bad_rate
    $error("unsupported terminal clock rate");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change counts once stages 2 and 3 agree

  logic [6:0] pin_s1_q;
  logic [6:0] pin_s2_q;
  logic [6:0] pin_s3_q;
  logic [6:0] pin_q;
  logic [1:0] inh_sync_q;
  logic       inh_s3_q;
  logic       inh_q;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin // [RL15]
      pin_s1_q <= 7'h40; // latch bit high: a latch strap tied high makes no false edge
      pin_s2_q <= 7'h40;
      pin_s3_q <= 7'h40;
      pin_q    <= 7'h40;
    end else if (i_ce) begin
      pin_s1_q <= {i_address_latch_control, i_terminal_address_parity_pin,
                   i_terminal_address_pins};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int i = 0; i < 7; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      inh_sync_q <= 2'h0;
      inh_s3_q   <= 1'b0;
      inh_q      <= 1'b0;
    end else if (i_ce) begin
      inh_sync_q <= {inh_sync_q[0], i_transmitter_inhibit};
      inh_s3_q   <= inh_sync_q[1];
      if (inh_sync_q[1] == inh_s3_q) begin
        inh_q <= inh_s3_q;
      end
    end
  end

  wire logic        latch_lvl = pin_q[6];
  wire rtadr_pkg::rtadr_addr_t pin_addr = pin_q[5:0];

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  logic [15:0] cfg3_q;
  logic [15:0] cfg4_q;
  logic [15:0] cfg5_q;
  logic [15:0] cfg6_q;
  logic [15:0] cfg7_q;
  logic [1:0]  mode_q;
  logic        aw_got_q;
  logic        w_got_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_go;
  logic        cfg5_wr;

  assign wr_go   = aw_got_q && w_got_q && !o_bvalid;
  // [RL17] only low-half or full-word writes move bits into the registers
  assign cfg5_wr = wr_go && awaddr_q == rtadr_pkg::CFG5_OFF && wstrb_q[1:0] == 2'h3;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= rtadr_pkg::AXI_OKAY;
    end else if (i_ce) begin
      o_awready <= !aw_got_q && !(i_awvalid && o_awready);
      o_wready  <= !w_got_q && !(i_wvalid && o_wready);
      if (i_awvalid && o_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= {i_awaddr[7:2], 2'b00};
      end
      if (i_wvalid && o_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end
      if (wr_go) begin
        o_bvalid <= 1'b1;
        // single-byte writes into a 16-bit slot are refused
        o_bresp  <= (wstrb_q[1] ^ wstrb_q[0]) ? rtadr_pkg::AXI_SLVERR :
                    rtadr_pkg::AXI_OKAY;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cfg3_q <= rtadr_pkg::CFG_RST;
      cfg4_q <= rtadr_pkg::CFG_RST;
      cfg5_q <= rtadr_pkg::CFG_RST;
      cfg6_q <= rtadr_pkg::CFG_RST;
      cfg7_q <= rtadr_pkg::CFG_RST;
      mode_q <= rtadr_pkg::MODE_RST;
    end else if (i_ce && wr_go && wstrb_q[1:0] == 2'h3) begin
      if (awaddr_q == rtadr_pkg::CFG3_OFF) begin
        cfg3_q <= wdata_q[15:0];
      end else if (awaddr_q == rtadr_pkg::CFG4_OFF) begin
        cfg4_q <= wdata_q[15:0];
      end else if (awaddr_q == rtadr_pkg::CFG5_OFF) begin
        cfg5_q <= wdata_q[15:0];
      end else if (awaddr_q == rtadr_pkg::CFG6_OFF) begin
        cfg6_q <= wdata_q[15:0];
      end else if (awaddr_q == rtadr_pkg::CFG7_OFF) begin
        cfg7_q <= wdata_q[15:0];
      end else if (awaddr_q == rtadr_pkg::MODE_OFF) begin
        mode_q <= wdata_q[1:0];
      end
    end
  end

  wire logic src_sel  = cfg6_q[rtadr_pkg::SRC_BIT];
  wire logic func_sel = cfg7_q[rtadr_pkg::FUNC_BIT];
  wire logic wr_latch = cfg5_wr && cfg3_q[rtadr_pkg::ENH_BIT] &&
                        cfg4_q[rtadr_pkg::LATCH5_BIT];
  wire rtadr_pkg::rtadr_addr_t host_addr = wdata_q[5:0];

  ////////////////////////////////////////////////////////////////////////////
  // address latch

  logic        latch_d1_q;
  rtadr_pkg::rtadr_addr_t held_q;
  rtadr_pkg::rtadr_addr_t eff_addr;
  logic        latch_rise;

  assign latch_rise = latch_lvl && !latch_d1_q;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      latch_d1_q <= 1'b1;
      held_q     <= 6'h00;
    end else if (i_ce) begin
      latch_d1_q <= latch_lvl;
      if (wr_latch) begin
        held_q <= src_sel ? host_addr : pin_addr; // [RL2] [RL8]
      end else if (latch_rise && !src_sel) begin
        held_q <= pin_addr; // [RL5]
      end
      // otherwise held_q keeps its value [RL18]
    end
  end

  always_comb begin
    if (src_sel) begin
      eff_addr = held_q; // [RL2] pins not used
    end else if (!latch_lvl || latch_rise) begin
      // on the rising edge the pins go through, so no stale held value slips out
      eff_addr = pin_addr; // [RL1] [RL4]
    end else begin
      eff_addr = held_q;
    end
  end
  logic [5:0] eff_q;
  logic       ok_q;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      eff_q              <= 6'h00;
      ok_q               <= 1'b0;
      o_terminal_address <= 6'h00;
      o_address_ok       <= 1'b0;
      o_respond          <= 1'b0;
      o_tx_enable_a      <= 1'b0;
      o_tx_enable_b      <= 1'b0;
    end else if (i_ce) begin
      eff_q              <= eff_addr;
      ok_q               <= ^eff_addr; // [RL3]
      o_terminal_address <= eff_q;
      o_address_ok       <= ok_q;
      o_respond          <= i_nonbcast_cmd && ok_q; // [RL3]
      o_tx_enable_a      <= !inh_q; // [RL14]
      o_tx_enable_b      <= !inh_q; // [RL14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared discrete output

  logic [1:0] pulse_cnt_q;
  logic       online;
  rtadr_pkg::rtadr_mode_t mode;

  assign mode   = rtadr_pkg::rtadr_mode_t'(mode_q);
  assign online = cfg3_q[rtadr_pkg::ONLINE_BIT];

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pulse_cnt_q  <= 2'h0;
      o_discrete_n <= 1'b1;
    end else if (i_ce) begin
      if (i_reset_cmd && func_sel && mode == rtadr_pkg::RTADR_MODE_TERM) begin
        pulse_cnt_q <= 2'(rtadr_pkg::PULSE_CLKS); // [RL12]
      end else if (pulse_cnt_q != 2'h0) begin
        pulse_cnt_q <= pulse_cnt_q - 2'h1;
      end
      if (func_sel) begin // [RL9]
        // [RL12] [RL13] only terminal mode pulses
        o_discrete_n <= !(mode == rtadr_pkg::RTADR_MODE_TERM && pulse_cnt_q != 2'h0);
      end else if (mode == rtadr_pkg::RTADR_MODE_WMON) begin
        o_discrete_n <= !online; // [RL11]
      end else begin
        o_discrete_n <= !i_msg_busy; // [RL10]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read side

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= rtadr_pkg::AXI_OKAY;
    end else if (i_ce) begin
      o_arready <= !o_rvalid && !(i_arvalid && o_arready);
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rresp  <= rtadr_pkg::AXI_OKAY;
        if (i_araddr[7:2] == rtadr_pkg::CFG3_OFF[7:2]) begin
          o_rdata <= {16'h0000, cfg3_q};
        end else if (i_araddr[7:2] == rtadr_pkg::CFG4_OFF[7:2]) begin
          o_rdata <= {16'h0000, cfg4_q};
        end else if (i_araddr[7:2] == rtadr_pkg::CFG5_OFF[7:2]) begin
          o_rdata <= {16'h0000, cfg5_q};
        end else if (i_araddr[7:2] == rtadr_pkg::CFG6_OFF[7:2]) begin
          o_rdata <= {16'h0000, cfg6_q};
        end else if (i_araddr[7:2] == rtadr_pkg::CFG7_OFF[7:2]) begin
          o_rdata <= {16'h0000, cfg7_q};
        end else if (i_araddr[7:2] == rtadr_pkg::STAT_OFF[7:2]) begin
          o_rdata <= {16'h0000, 8'h00, inh_q, ok_q, eff_q}; // block state
        end else if (i_araddr[7:2] == rtadr_pkg::MODE_OFF[7:2]) begin
          o_rdata <= {30'h0000_0000, mode_q};
        end else begin
          o_rdata <= 32'h0000_0000; // rest of the 00h..fch window reads zero
        end
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_pulse_two_cycles: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL12]
    (i_ce && i_reset_cmd && func_sel && mode == rtadr_pkg::RTADR_MODE_TERM) ##1 i_ce
      |=> !o_discrete_n ##1 !o_discrete_n)
    else $error("reset pulse not held low two cycles");
  a_pulse_mon_high: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL13]
    (func_sel && mode != rtadr_pkg::RTADR_MODE_TERM && $stable(mode_q) && $stable(cfg7_q)
      && i_ce) |=> o_discrete_n)
    else $error("discrete low in non-terminal pulse mode");
  a_busy_low: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL10]
    (i_rst_n && i_ce && !func_sel && mode != rtadr_pkg::RTADR_MODE_WMON && i_msg_busy) |=>
      (!o_discrete_n || !i_ce || $changed(cfg7_q) || $changed(mode_q)))
    else $error("in-progress not low while busy");
  a_wmon_online: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL11]
    (i_rst_n && i_ce && !func_sel && mode == rtadr_pkg::RTADR_MODE_WMON && online) |=>
      (!o_discrete_n || $changed(cfg7_q) || $changed(mode_q) || $changed(cfg3_q)))
    else $error("in-progress not low while online");
  a_parity_ok: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL3]
    i_ce ##1 i_ce |=> o_address_ok == ^$past(eff_addr, 2))
    else $error("address parity flag wrong");
  a_inhibit_tx: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL14]
    (i_ce && inh_q) |=> (!o_tx_enable_a && !o_tx_enable_b))
    else $error("transmitter not shut down");
  a_host_latch: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL2]
    (i_ce && wr_latch && src_sel) |=> held_q == $past(host_addr))
    else $error("host address not latched");
  a_pin_latch: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL8]
    (i_ce && wr_latch && !src_sel) |=> held_q == $past(pin_addr))
    else $error("pin address not latched on write");
  a_hold_latch: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL18]
    (!wr_latch && !(latch_rise && !src_sel)) |=> $stable(held_q))
    else $error("latched address changed without event");
  a_transparent: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RL4]
    (i_rst_n && i_ce && !src_sel && !latch_lvl) ##1 i_ce |=>
      o_terminal_address == $past(pin_addr, 2))
    else $error("pin address not transparent");
endmodule

// ==== pkg/rtadr_pkg.sv ====
// package for the terminal address and discrete output block
// assumes an axi4-lite host with 32-bit data and a 125 MHz core clock
package rtadr_pkg;

  // register byte offsets (16-bit registers in the low half of each word)
  localparam logic [7:0] CFG3_OFF   = 8'h0c;
  localparam logic [7:0] CFG4_OFF   = 8'h10;
  localparam logic [7:0] CFG5_OFF   = 8'h14;
  localparam logic [7:0] CFG6_OFF   = 8'h18;
  localparam logic [7:0] CFG7_OFF   = 8'h1c;
  localparam logic [7:0] STAT_OFF   = 8'h20;
  localparam logic [7:0] MODE_OFF   = 8'h24;
  localparam logic [7:0] LAST_OFF   = 8'hfc;

  // field positions
  localparam int ENH_BIT      = 15;
  localparam int LATCH5_BIT   = 3;
  localparam int SRC_BIT      = 5;
  localparam int FUNC_BIT     = 0;
  localparam int ONLINE_BIT   = 2;

  // reset values
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [1:0]  MODE_RST = 2'h1;

  // timing
  localparam int CLK_MHZ        = 125;
  localparam int PULSE_CLKS     = 2;
  localparam int TERM_MHZ_MIN   = 10;
  localparam int TERM_MHZ_MAX   = 20;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RTADR_MODE_CTRL = 2'b00,
    RTADR_MODE_TERM = 2'b01,
    RTADR_MODE_SMON = 2'b10,
    RTADR_MODE_WMON = 2'b11
  } rtadr_mode_t;

  // terminal address with its parity
  typedef struct packed {
    logic       par;
    logic [4:0] addr;
  } rtadr_addr_t;

endpackage

// ==== testbench/rtadr_bench.sv ====
// self-checking bench: axi4-lite host tasks, strap model, expected values by model
// assumes the design answers on axi without a fixed latency
////////////////////////////////////////////////////////////////////////////////
module rtadr_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        inh = 1'b0, busy = 1'b0, rcmd = 1'b0, nbc = 1'b0, ce = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0]  wstrb = 4'h0;
  logic        awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic        awrdy, wrdy, bv, arrdy, rv, aok, resp, txa, txb, disc_n, par, lat;
  logic [1:0]  bresp, rresp, r;
  logic [5:0]  taddr, m_addr;
  logic [4:0]  pins;
  int          mismatches = 0, n_checks = 0, cyc = 0, seed = 92;

  always #4 clk = ~clk;

  rtadr_strap_model strap (.i_clk(clk), .o_pins(pins), .o_par(par), .o_lat(lat));

  rtadr_top #(.TERM_CLK_MHZ(16)) dut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_terminal_address_pins(pins),
    .i_terminal_address_parity_pin(par), .i_address_latch_control(lat),
    .i_transmitter_inhibit(inh), .i_msg_busy(busy), .i_reset_cmd(rcmd),
    .i_nonbcast_cmd(nbc), .i_awaddr(awaddr), .i_awvalid(awv), .o_awready(awrdy),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wv), .o_wready(wrdy), .o_bresp(bresp),
    .o_bvalid(bv), .i_bready(brdy), .i_araddr(araddr), .i_arvalid(arv),
    .o_arready(arrdy), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv), .i_rready(rrdy),
    .o_terminal_address(taddr), .o_address_ok(aok), .o_respond(resp),
    .o_tx_enable_a(txa), .o_tx_enable_b(txb), .o_discrete_n(disc_n));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (mismatches == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // a hang shows up here, well past the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // outputs are looked at mid-cycle, where they have settled
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                    output logic [1:0] rs);
    logic pa, pw, ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata  <= v;
    wstrb  <= s;
    awv    <= 1'b1;
    wv     <= 1'b1;
    brdy   <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    tb = 1'b0;
    while (pa || pw) begin
      @(negedge clk);
      ta = pa && awrdy;
      tw = pw && wrdy;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    while (!tb) begin
      @(negedge clk);
      tb = bv;
      rs = bresp;
      @(posedge clk);
    end
    brdy <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic t;
    @(posedge clk);
    araddr <= a;
    arv    <= 1'b1;
    rrdy   <= 1'b1;
    t = 1'b0;
    while (!t) begin
      @(negedge clk);
      t = arrdy;
      @(posedge clk);
    end
    arv <= 1'b0;
    t = 1'b0;
    while (!t) begin
      @(negedge clk);
      t = rv;
      v = rdata;
      rs = rresp;
      @(posedge clk);
    end
    rrdy <= 1'b0;
  endtask

  task automatic chk_addr;
    settle(10);
    chk("address", taddr, m_addr);
    chk("ok", aok, ^m_addr);
    chk("respond", resp, nbc & ^m_addr);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(8'h0c + 8'(4 * i), d, r);
      if (i != 5) chk("reset value", d, (i == 6) ? 32'h1 : 32'h0);
    end
    rd(8'h40, d, r);
    chk("unmapped", {d[29:0], r}, 32'h0);
    // transparent straps with random values, parity left to chance
    nbc <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      m_addr = d[5:0];
      nbc <= d[6];
      strap.strap(m_addr);
      chk_addr();
      rd(rtadr_pkg::STAT_OFF, d, r);
      chk("status", d & 32'hff, {^m_addr, m_addr});
    end
    // rising latch edge holds the value through later strap changes
    m_addr = 6'h25;
    strap.strap(m_addr);
    settle(8);
    strap.latch(1'b1);
    chk_addr();
    strap.strap(6'h1a);
    chk_addr();
    // host latch with source on the pins: register data is ignored
    wr(rtadr_pkg::CFG3_OFF, 32'h8000, 4'hf, r);
    wr(rtadr_pkg::CFG4_OFF, 32'h0008, 4'hf, r);
    m_addr = 6'h0b;
    strap.strap(m_addr);
    settle(8);
    wr(rtadr_pkg::CFG5_OFF, 32'h3f, 4'h3, r);
    chk_addr();
    // host latch with source on the register
    wr(rtadr_pkg::CFG6_OFF, 32'h20, 4'hf, r);
    m_addr = 6'h31;
    wr(rtadr_pkg::CFG5_OFF, 32'h31, 4'hf, r);
    chk_addr();
    strap.strap(6'h07);
    chk_addr();
    wr(rtadr_pkg::CFG5_OFF, 32'h0e, 4'h1, r);
    chk("byte write", r, rtadr_pkg::AXI_SLVERR);
    wr(rtadr_pkg::CFG5_OFF, 32'h0e, 4'hc, r);
    chk("upper write", r, rtadr_pkg::AXI_OKAY);
    chk_addr();
    // transmitter inhibit both ways
    @(posedge clk) inh <= 1'b1;
    settle(8);
    chk("tx off", {txa, txb}, 2'b00);
    @(posedge clk) begin
      inh <= 1'b0;
      ce  <= 1'b0;
    end
    settle(8);
    chk("tx frozen", {txa, txb}, 2'b00);
    @(posedge clk) ce <= 1'b1;
    settle(8);
    chk("tx on", {txa, txb}, 2'b11);
    // in-progress indicator in every mode
    for (int m = 0; m < 4; m++) begin
      wr(rtadr_pkg::MODE_OFF, 32'(m), 4'hf, r);
      wr(rtadr_pkg::CFG3_OFF, (m == 3) ? 32'h8004 : 32'h8000, 4'hf, r);
      @(posedge clk) busy <= 1'b1;
      settle(4);
      chk("in progress", disc_n, 1'b0);
      @(posedge clk) busy <= 1'b0;
      wr(rtadr_pkg::CFG3_OFF, 32'h8000, 4'hf, r);
      settle(4);
      chk("idle", disc_n, 1'b1);
    end
    // reset pulse: only terminal mode pulses, busy must not leak through
    wr(rtadr_pkg::CFG7_OFF, 32'h1, 4'hf, r);
    @(posedge clk) busy <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(rtadr_pkg::MODE_OFF, 32'(m), 4'hf, r);
      @(posedge clk) rcmd <= 1'b1;
      @(posedge clk) rcmd <= 1'b0;
      for (int k = 0; k < 5; k++) begin
        @(negedge clk);
        chk("pulse", disc_n, (m == 1) ? 5'b10011 >> (4 - k) & 5'h1 : 5'h1);
      end
    end
    // master clear in mid-run
    @(posedge clk) rst_n <= 1'b0;
    settle(2);
    chk("clear out", {disc_n, txa, txb}, 3'b100);
    @(posedge clk) rst_n <= 1'b1;
    rd(rtadr_pkg::CFG7_OFF, d, r);
    chk("clear reg", d, 32'h0);
    results();
  end
endmodule

// ==== testbench/rtadr_strap_model.sv ====
// board strap field and latch control seen by the terminal address pins
// assumes the bench calls its tasks from one clocked sequence
////////////////////////////////////////////////////////////////////////////////
module rtadr_strap_model (
  input  wire logic i_clk,
  output logic [4:0] o_pins,
  output logic       o_par,
  output logic       o_lat
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_pins = 5'h01;
    o_par  = 1'b0;
    o_lat  = 1'b0;
  end
  // straps move only after an edge, never on it
  task automatic strap(input logic [5:0] v);
    @(posedge i_clk);
    o_par  <= v[5];
    o_pins <= v[4:0];
  endtask
  task automatic latch(input logic v);
    @(posedge i_clk);
    o_lat <= v;
  endtask
endmodule
